// [hw/pgx_regs.vh]
/*
 * Register offsets, field positions, reset values and timing counts
 * of the three-pin general-purpose port. Included by the top-level design file.
 */
`ifndef PGX_REGS_VH
`define PGX_REGS_VH

`define PGX_OFF_CFG0       8'h00
`define PGX_OFF_CFG1       8'h04
`define PGX_OFF_CFG2       8'h08
`define PGX_OFF_INT        8'h0C
`define PGX_OFF_INTM       8'h10
`define PGX_OFF_GLBL       8'h14
`define PGX_OFF_RAIL       8'h18

`define PGX_CFG_DIR        0
`define PGX_CFG_DI         1
`define PGX_CFG_DRV        2
`define PGX_CFG_DO         3
`define PGX_CFG_DBEN       4
`define PGX_CFG_ALT        5

`define PGX_CFG_RESET      6'h01
`define PGX_INTM_RESET     6'h3F
`define PGX_GLBL_LPM       0
`define PGX_RAIL_RESET     3'h0

`define PGX_CLK_MHZ        100
`define PGX_DBNC_MS        30
`define PGX_OSC_DIV        10
`define PGX_OSC_LAST       4'h9
`define PGX_DBNC_TICKS     ((`PGX_DBNC_MS * 1000 * `PGX_CLK_MHZ) / `PGX_OSC_DIV)

`endif

// [hw/pgx_debounce.v]
/*
 * Per-pin debounce filter for the port: a level is accepted only after
 * the raw input holds it for the full interval, counted in ticks.
 * Assumes a one-cycle tick enable and inputs synchronous to the clock.
 */
`timescale 1ns/10ps
module pgx_debounce
#(
  parameter DBNC_TICKS = 300000
)
(
  input  wire clk,
  input  wire rst,
  input  wire tick,
  input  wire enable,
  input  wire raw,
  output reg  level_q
);

  reg [18:0] cnt_q;

  always @(posedge clk)
  begin
    if (rst)
    begin
      cnt_q   <= 19'h0_0000;
      level_q <= 1'b0;
    end
    else if (!enable)
    begin
      cnt_q   <= 19'h0_0000;
      level_q <= raw;
    end
    else if (raw == level_q)
    begin
      cnt_q <= 19'h0_0000;
    end
    else if (tick)
    begin
      if (cnt_q >= DBNC_TICKS[18:0] - 19'h0_0001)
      begin
        cnt_q   <= 19'h0_0000;
        level_q <= raw;
      end
      else
      begin
        cnt_q <= cnt_q + 19'h0_0001;
      end
    end
  end

endmodule

// [hw/pgx_top.v]
/*
 * Three general-purpose pins with debounce, edge interrupts and
 * alternate functions, with registers on an AHB-Lite slave.
 * Assumes one AHB-Lite master, single word transfers, pins synchronous.
 */
// Notes on behaviour
// RULE1: Direction bit clear makes pin output; set makes it input.
// RULE2: Drive type 1 is push-pull; 0 is open-drain, pulling low only.
// RULE3: Input level status follows the pin even in output mode.
// RULE4: Input mode offers a 30ms debounce, switched per pin.
// RULE5: Debounce enable 1 filters input; 0 bypasses the filter.
// RULE6: Debounce interval timed by its own internal oscillator tick; here a tick from MCLK divided by ten.
// RULE7: Rising and falling edges reported as separate events.
// RULE8: Each edge has its own mask; 0 lets it assert interrupt.
// RULE9: Each pin has readable alternate-function bit, 1 selects it.
// RULE10: Pin 0 alternate drives sequencer slot of rail two, active high.
// RULE11: Pin 1 alternate: rail two on if pin high or sequencer enables.
// RULE12: Codes 100 and 101 need pin 1 high; other codes stay enabled.
// RULE13: Pin 2 alternate input ORed with bias low-power bit.
// RULE14: Interrupt output low while any unmasked flag is set.
// RULE15: All interrupt masks set after reset.
// RULE16: Debounced level accepted only after holding for full interval.
// RULE17: Edge flags latch until software writes one to clear.
`timescale 1ns/10ps
`include "pgx_regs.vh"
module pgx_top
#(
  parameter DBNC_TICKS = `PGX_DBNC_TICKS
)
(
  input  wire        MCLK,
  input  wire        RST,
  input  wire        HSEL,
  input  wire [31:0] HADDR,
  input  wire [1:0]  HTRANS,
  input  wire        HWRITE,
  input  wire [2:0]  HSIZE,
  input  wire [31:0] HWDATA,
  input  wire        HREADY,
  output reg  [31:0] HRDATA,
  output reg         HREADYOUT,
  output reg         HRESP,
  input  wire [2:0]  PIN_I,
  output reg  [2:0]  PIN_O,
  output reg  [2:0]  PIN_OE,
  input  wire        SEQ_SLOT_RAIL2,
  input  wire        SEQ_EN_RAIL2,
  output reg         RAIL2_ENABLE,
  output reg         BIAS_LPM_REQ,
  output reg         IRQ_N,
  output reg         IRQ
);

  reg  [5:0] cfg_q [0:2];
  reg  [5:0] int_q;
  reg  [5:0] intm_q;
  reg        lpm_q;
  reg  [2:0] rail_code_q;
  reg  [2:0] in_prev_q;
  reg  [3:0] tick_cnt_q;
  reg        tick_q;
  reg        wr_pend_q;
  reg  [7:0] wr_addr_q;
  wire [2:0] in_lvl;
  wire [5:0] evt;
  reg  [5:0] int_d;
  wire       take;
  wire       wr_cfg_hit;
  reg  [31:0] rdata_d;

  function is_cfg;
    input [7:0] a;
    begin
      is_cfg = (a == `PGX_OFF_CFG0) || (a == `PGX_OFF_CFG1) ||
               (a == `PGX_OFF_CFG2);
    end
  endfunction

  function [1:0] cfg_idx;
    input [7:0] a;
    begin
      cfg_idx = a[3:2];
    end
  endfunction

  // Separate debounce time base, divided down from the bus clock MCLK
  always @(posedge MCLK)
  begin
    if (RST)
    begin
      tick_cnt_q <= 4'h0;
      tick_q     <= 1'b0;
    end
    else if (tick_cnt_q == `PGX_OSC_LAST)
    begin
      // Counter must reach nine, so it needs four bits
      tick_cnt_q <= 4'h0;
      tick_q     <= 1'b1; // RULE6
    end
    else
    begin
      tick_cnt_q <= tick_cnt_q + 4'h1;
      tick_q     <= 1'b0;
    end
  end

  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1)
    begin : pin
      pgx_debounce #(.DBNC_TICKS(DBNC_TICKS)) u_dbnc
      (
        .clk     (MCLK),
        .rst     (RST),
        .tick    (tick_q),
        .enable  (cfg_q[g][`PGX_CFG_DBEN] & cfg_q[g][`PGX_CFG_DIR]), // RULE5
        .raw     (PIN_I[g]),
        .level_q (in_lvl[g])  // RULE4 RULE16
      );
      assign evt[g]     = in_lvl[g] & ~in_prev_q[g];  // RULE7
      assign evt[g + 3] = ~in_lvl[g] & in_prev_q[g];  // RULE7
    end
  endgenerate

  // Pin drive
  always @(posedge MCLK)
  begin
    if (RST)
    begin
      PIN_O  <= 3'h0;
      PIN_OE <= 3'h0;
    end
    else
    begin
      if (cfg_q[0][`PGX_CFG_ALT])
      begin
        PIN_O[0]  <= SEQ_SLOT_RAIL2; // RULE10
        PIN_OE[0] <= 1'b1;
      end
      else
      begin
        PIN_O[0]  <= cfg_q[0][`PGX_CFG_DO] & cfg_q[0][`PGX_CFG_DRV];
        PIN_OE[0] <= ~cfg_q[0][`PGX_CFG_DIR] & (cfg_q[0][`PGX_CFG_DRV] |
                     ~cfg_q[0][`PGX_CFG_DO]); // RULE1 RULE2
      end
      // Alternate modes of pins 1 and 2 are inputs
      PIN_O[1]  <= cfg_q[1][`PGX_CFG_DO] & cfg_q[1][`PGX_CFG_DRV];
      PIN_OE[1] <= ~cfg_q[1][`PGX_CFG_ALT] & ~cfg_q[1][`PGX_CFG_DIR] &
                   (cfg_q[1][`PGX_CFG_DRV] | ~cfg_q[1][`PGX_CFG_DO]);
      PIN_O[2]  <= cfg_q[2][`PGX_CFG_DO] & cfg_q[2][`PGX_CFG_DRV];
      PIN_OE[2] <= ~cfg_q[2][`PGX_CFG_ALT] & ~cfg_q[2][`PGX_CFG_DIR] &
                   (cfg_q[2][`PGX_CFG_DRV] | ~cfg_q[2][`PGX_CFG_DO]);
    end
  end

  // Alternate functions of pins 1 and 2
  always @(posedge MCLK)
  begin
    if (RST)
    begin
      RAIL2_ENABLE <= 1'b0;
      BIAS_LPM_REQ <= 1'b0;
    end
    else
    begin
      if (cfg_q[1][`PGX_CFG_ALT])
      begin
        case (rail_code_q)
          3'h4, 3'h5:
            RAIL2_ENABLE <= PIN_I[1] | SEQ_EN_RAIL2; // RULE11 RULE12
          default:
            RAIL2_ENABLE <= 1'b1; // RULE12
        endcase
      end
      else
      begin
        RAIL2_ENABLE <= SEQ_EN_RAIL2;
      end
      BIAS_LPM_REQ <= lpm_q | (cfg_q[2][`PGX_CFG_ALT] & PIN_I[2]); // RULE13
    end
  end

  // AHB-Lite slave: zero wait states, write data taken in data phase
  assign take = HSEL & HREADY & HTRANS[1];
  assign wr_cfg_hit = wr_pend_q & is_cfg(wr_addr_q);

  always @*
  begin
    rdata_d = 32'h0000_0000;
    if (is_cfg(HADDR[7:0]))
    begin
      rdata_d[5:0] = cfg_q[cfg_idx(HADDR[7:0])];
      rdata_d[`PGX_CFG_DI] = PIN_I[cfg_idx(HADDR[7:0])]; // RULE3 RULE9
    end
    else if (HADDR[7:0] == `PGX_OFF_INT)
      rdata_d[5:0] = int_q;
    else if (HADDR[7:0] == `PGX_OFF_INTM)
      rdata_d[5:0] = intm_q;
    else if (HADDR[7:0] == `PGX_OFF_GLBL)
      rdata_d[`PGX_GLBL_LPM] = lpm_q;
    else if (HADDR[7:0] == `PGX_OFF_RAIL)
      rdata_d[2:0] = rail_code_q;
  end

  integer i;
  always @(posedge MCLK)
  begin
    if (RST)
    begin
      wr_pend_q   <= 1'b0;
      wr_addr_q   <= 8'h00;
      HRDATA      <= 32'h0000_0000;
      HREADYOUT   <= 1'b1;
      HRESP       <= 1'b0;
      for (i = 0; i < 3; i = i + 1)
        cfg_q[i] <= `PGX_CFG_RESET;
      intm_q      <= `PGX_INTM_RESET; // RULE15
      lpm_q       <= 1'b0;
      rail_code_q <= `PGX_RAIL_RESET;
    end
    else
    begin
      wr_pend_q <= take & HWRITE;
      if (take)
        wr_addr_q <= HADDR[7:0];
      if (take & ~HWRITE)
        HRDATA <= rdata_d;
      if (wr_cfg_hit)
      begin
        cfg_q[cfg_idx(wr_addr_q)] <= HWDATA[5:0] &
                                     6'h3D; // Status bit is read-only
      end
      if (wr_pend_q && wr_addr_q == `PGX_OFF_INTM)
        intm_q <= HWDATA[5:0];
      if (wr_pend_q && wr_addr_q == `PGX_OFF_GLBL)
        lpm_q <= HWDATA[`PGX_GLBL_LPM];
      if (wr_pend_q && wr_addr_q == `PGX_OFF_RAIL)
        rail_code_q <= HWDATA[2:0];
    end
  end

  // Sticky flags; a new event wins over a same-cycle clear
  always @*
  begin
    int_d = int_q;
    if (wr_pend_q && wr_addr_q == `PGX_OFF_INT)
      int_d = int_d & ~HWDATA[5:0];
    int_d = int_d | evt; // RULE17
  end

  always @(posedge MCLK)
  begin
    if (RST)
    begin
      int_q     <= 6'h00;
      in_prev_q <= 3'h0;
      IRQ_N     <= 1'b1;
      IRQ       <= 1'b0;
    end
    else
    begin
      int_q     <= int_d;
      in_prev_q <= in_lvl;
      IRQ_N     <= ~|(int_d & ~intm_q); // RULE8 RULE14
      IRQ       <= |(int_d & ~intm_q);
    end
  end

endmodule

// [testbench/pgx_chk_assertions.sv]
/* Port checker for pgx_top, bound at the foot.
   Assumes one clock and a synchronous reset. */
`timescale 1ns/10ps
module pgx_chk
(
  input wire        MCLK,
  input wire        RST,
  input wire        HSEL,
  input wire        HREADY,
  input wire [1:0]  HTRANS,
  input wire        HWRITE,
  input wire [31:0] HRDATA,
  input wire        HREADYOUT,
  input wire        HRESP,
  input wire [2:0]  PIN_O,
  input wire [2:0]  PIN_OE,
  input wire        SEQ_SLOT_RAIL2,
  input wire        SEQ_EN_RAIL2,
  input wire        RAIL2_ENABLE,
  input wire        IRQ_N,
  input wire        IRQ
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (RST);
  wire       tk = HSEL & HREADY & HTRANS[1];
  reg  [2:0] wr_q;
  reg        rd_q;
  reg        rst_q;
  // A write shows two or three edges after its address phase
  wire       cause = wr_q[1] | wr_q[2] | rst_q;
  always @(posedge MCLK)
  begin
    wr_q  <= {wr_q[1:0], tk & HWRITE};
    rd_q  <= tk & ~HWRITE;
    rst_q <= RST;
  end
  sequence s_quiet;
    IRQ_N [*2];
  endsequence
  property p_pair; IRQ_N == !IRQ; endproperty
  a_pair: assert property (p_pair) else $error("irq pair");
  property p_rst; $fell(RST) |-> s_quiet; endproperty
  a_rst: assert property (p_rst) else $error("irq after reset");
  property p_clr; $rose(IRQ_N) |-> cause; endproperty
  a_clr: assert property (p_clr) else $error("flag lost");
  property p_rail; SEQ_EN_RAIL2 |=> RAIL2_ENABLE; endproperty
  a_rail: assert property (p_rail) else $error("rail off");
  property p_oe; $changed(PIN_OE) |-> cause; endproperty
  a_oe: assert property (p_oe) else $error("enable moved");
  property p_drv; $changed(PIN_O[2:1]) |-> cause; endproperty
  a_drv: assert property (p_drv) else $error("drive moved");
  property p_slot;
    $changed(PIN_O[0]) |-> cause || PIN_O[0] == $past(SEQ_SLOT_RAIL2);
  endproperty
  a_slot: assert property (p_slot) else $error("slot");
  property p_hold; !rd_q && !rst_q |-> $stable(HRDATA); endproperty
  a_hold: assert property (p_hold) else $error("read data");
  property p_okay; !HRESP && HREADYOUT; endproperty
  a_okay: assert property (p_okay) else $error("bus response");
endmodule

bind pgx_top pgx_chk pgx_chk_i (.MCLK(MCLK), .RST(RST), .HSEL(HSEL),
  .HREADY(HREADY), .HTRANS(HTRANS), .HWRITE(HWRITE), .HRDATA(HRDATA),
  .HREADYOUT(HREADYOUT), .HRESP(HRESP),
  .PIN_O(PIN_O), .PIN_OE(PIN_OE), .SEQ_SLOT_RAIL2(SEQ_SLOT_RAIL2),
  .SEQ_EN_RAIL2(SEQ_EN_RAIL2), .RAIL2_ENABLE(RAIL2_ENABLE),
  .IRQ_N(IRQ_N), .IRQ(IRQ));

// [testbench/pgx_pins.sv]
/* Outside world of the pins: pull-ups and optional drivers.
   Assumes the port never fights an external driver. */
`timescale 1ns/10ps
module pgx_pins
(
  input  wire [2:0] o,
  input  wire [2:0] oe,
  input  wire [2:0] ev,
  input  wire [2:0] eo,
  output wire [2:0] lvl
);
  // Undriven lines float up, as open-drain needs
  assign lvl = (oe & o) | (~oe & eo & ev) | (~oe & ~eo);
endmodule

// [testbench/testbench.sv]
/* Bench for pgx_top: bus tasks, pin stimulus, checks.
   Assumes pgx_top and pgx_pins are compiled first. */
`timescale 1ns/10ps
module testbench;
  logic        MCLK = 1'h0;
  logic        RST = 1'h1;
  logic        HSEL = 1'h0;
  logic        HWRITE = 1'h0;
  logic [1:0]  HTRANS = 2'h0;
  logic [2:0]  HSIZE = 3'h2;
  logic [31:0] HADDR = 32'h0;
  logic [31:0] HWDATA = 32'h0;
  logic        SEQ_SLOT_RAIL2 = 1'h0;
  logic        SEQ_EN_RAIL2 = 1'h0;
  logic [2:0]  ev = 3'h0;
  logic [2:0]  eo = 3'h0;
  wire  [31:0] HRDATA;
  wire  [2:0]  PIN_I, PIN_O, PIN_OE;
  wire         HREADYOUT, HRESP, RAIL2_ENABLE, BIAS_LPM_REQ, IRQ_N, IRQ;
  wire         HREADY = HREADYOUT;
  wire  [8:0]  ps = {BIAS_LPM_REQ, RAIL2_ENABLE, IRQ_N, PIN_OE, PIN_O};
  int          n_fail = 0;
  int          tests_run = 0;
  int          cyc = 0;
  int          c;
  always #5 MCLK = ~MCLK;
  pgx_top #(.DBNC_TICKS(5)) pgx_top_i (.MCLK(MCLK), .RST(RST),
    .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE),
    .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADY), .HRDATA(HRDATA),
    .HREADYOUT(HREADYOUT), .HRESP(HRESP), .PIN_I(PIN_I), .PIN_O(PIN_O),
    .PIN_OE(PIN_OE), .SEQ_SLOT_RAIL2(SEQ_SLOT_RAIL2),
    .SEQ_EN_RAIL2(SEQ_EN_RAIL2), .RAIL2_ENABLE(RAIL2_ENABLE),
    .BIAS_LPM_REQ(BIAS_LPM_REQ), .IRQ_N(IRQ_N), .IRQ(IRQ));
  pgx_pins pgx_pins_i (.o(PIN_O), .oe(PIN_OE), .ev(ev), .eo(eo),
    .lvl(PIN_I));
  task automatic ck(input logic [31:0] g, e);
    tests_run++;
    if (g !== e)
    begin
      n_fail++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic cp(input logic [8:0] m, e);
    ck({23'h0, ps & m}, {23'h0, e});
  endtask
  task automatic xf(input logic w, input logic [7:0] a, d,
                    output logic [31:0] r);
    @(posedge MCLK);
    HSEL <= 1'h1;
    HWRITE <= w;
    HADDR <= {24'h0, a};
    HTRANS <= 2'h2;
    do @(posedge MCLK); while (HREADY !== 1'h1);
    HTRANS <= 2'h0;
    HWDATA <= {24'h0, d};
    do @(posedge MCLK); while (HREADY !== 1'h1);
    r = HRDATA;
  endtask
  task automatic wr(input logic [7:0] a, d);
    logic [31:0] r;
    xf(1'h1, a, d, r);
  endtask
  task automatic rd(input logic [7:0] a, e);
    logic [31:0] r;
    xf(1'h0, a, 8'h0, r);
    ck(r, {24'h0, e});
  endtask
  // Ends off the edge so outputs have settled
  task automatic cy(input int n);
    repeat (n) @(posedge MCLK);
    @(negedge MCLK);
  endtask
  task automatic px(input logic [7:0] x);
    @(posedge MCLK);
    {SEQ_SLOT_RAIL2, SEQ_EN_RAIL2, eo, ev} <= x;
  endtask
  task automatic final_report;
    if (n_fail == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  always @(posedge MCLK)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      n_fail++;
      final_report;
    end
  end
  initial
  begin
    repeat (6) @(posedge MCLK);
    RST <= 1'h0;
    cy(1);
    cp(9'h1FF, 9'h040);
    for (c = 0; c < 12; c += 4)
      rd(c[7:0], 8'h03);
    rd(8'h10, 8'h3F);
    rd(8'h0C, 8'h07);
    rd(8'h40, 8'h00);
    wr(8'h0C, 8'h3F);
    rd(8'h0C, 8'h00);
    wr(8'h04, 8'h0C);
    cy(2);
    cp(9'h012, 9'h012);
    wr(8'h04, 8'h04);
    rd(8'h04, 8'h04);
    wr(8'h04, 8'h08);
    cy(2);
    cp(9'h012, 9'h000);
    rd(8'h04, 8'h0A);
    wr(8'h04, 8'h00);
    cy(2);
    cp(9'h012, 9'h010);
    wr(8'h04, 8'h01);
    // Let the released pin's rising flag land before clearing
    cy(4);
    wr(8'h0C, 8'h3F);
    wr(8'h10, 8'h1F);
    px(8'h20);
    cy(3);
    cp(9'h040, 9'h000);
    rd(8'h0C, 8'h20);
    wr(8'h0C, 8'h20);
    cy(2);
    cp(9'h040, 9'h040);
    px(8'h00);
    cy(3);
    cp(9'h040, 9'h040);
    rd(8'h0C, 8'h04);
    wr(8'h0C, 8'h3F);
    wr(8'h08, 8'h11);
    px(8'h20);
    cy(30);
    rd(8'h0C, 8'h00);
    cy(40);
    rd(8'h0C, 8'h20);
    wr(8'h04, 8'h21);
    px(8'h10);
    for (c = 0; c < 8; c++)
    begin
      wr(8'h18, c[7:0]);
      cy(2);
      cp(9'h080, (c == 4 || c == 5) ? 9'h000 : 9'h080);
    end
    wr(8'h18, 8'h05);
    px(8'h50);
    cy(2);
    cp(9'h080, 9'h080);
    px(8'h00);
    cy(2);
    cp(9'h080, 9'h080);
    wr(8'h08, 8'h21);
    px(8'h20);
    cy(2);
    cp(9'h100, 9'h000);
    px(8'h00);
    cy(2);
    cp(9'h100, 9'h100);
    px(8'h20);
    wr(8'h14, 8'h01);
    cy(2);
    cp(9'h100, 9'h100);
    wr(8'h00, 8'h20);
    px(8'h80);
    cy(2);
    cp(9'h009, 9'h009);
    px(8'h00);
    cy(2);
    cp(9'h009, 9'h008);
    final_report;
  end
endmodule
